// >>> hspcs_device.sv
// Module-side serial port with receive FIFO, flow control and command select
// Operation
// - Four lines: clear-to-send, command, receive, transmit
// - Clear-to-send low only while bytes accepted
// - Command low means bytes are register commands
// - Command high means bytes pass transparently
// - Command low at reset exit restores defaults
// - Host keeps command high during power-up
// - Host holds command low 450 ms first
// - Full duplex, same selectable rate both ends
`timescale 1ns/1ps

module hspcs_fifo #(
   parameter int W = 9,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   // Fill side
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Drain side
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   // Fill level
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } hspcs_fifo_st_t;

   hspcs_fifo_st_t st_r;
   hspcs_fifo_st_t st_nxt;
   logic [W-1:0] mem_r [DEPTH];
   logic push;
   logic pop;

   assign count = st_r.wr - st_r.rd;
   assign in_ready = ce & (count != (AW+1)'(DEPTH));
   assign out_valid = ce & (st_r.wr != st_r.rd);
   assign out_data = mem_r[st_r.rd[AW-1:0]];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.wr = st_r.wr + (AW+1)'(1);
      end
      if (pop) begin
         st_nxt.rd = st_r.rd + (AW+1)'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   // Storage needs no reset; unread slots are never presented
   always_ff @(posedge clock) begin
      if (push) begin
         mem_r[st_r.wr[AW-1:0]] <= in_data;
      end
   end
endmodule : hspcs_fifo

module hspcs_device
   import hspcs_pkg::*;
#(
   parameter int CLK_HZ_P = CLK_HZ
) (
   // Clock, reset and enable
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   // Host lines
   hspcs_link_if.dev link,
   // Received bytes; cmd flag set when taken in command mode
   output logic [7:0] rx_data,
   output logic rx_cmd,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic rx_overrun,
   // Bytes to send to the host
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   // Mode, rate and default restore
   output logic cmd_mode,
   input wire logic [2:0] rate_sel,
   input wire logic rate_wr,
   output logic [2:0] rate,
   output logic defaults_restored
);
   localparam int CNT_W = $clog2(FIFO_DEPTH) + 1;
   localparam logic [CNT_W-1:0] CTS_LIMIT = CNT_W'(FIFO_DEPTH - CTS_SLACK);

   typedef struct packed {
      hspcs_dv_state_t state;
      logic [1:0] settle;
      logic s_rxd1;
      logic s_rxd2;
      logic s_cmd1;
      logic s_cmd2;
      logic [2:0] rate;
      logic restore;
      logic cmd_mode;
      logic cts_n;
      logic rx_cmd;
      logic overrun;
      hspcs_rx_t rx;
      hspcs_tx_t tx;
   } hspcs_dv_st_t;

   localparam hspcs_dv_st_t ST_RST = '{
      state: DV_BOOT, settle: 2'h0, s_rxd1: 1'h1, s_rxd2: 1'h1, s_cmd1: 1'h1,
      s_cmd2: 1'h1, rate: RATE_DEFAULT, restore: 1'h0, cmd_mode: 1'h0, cts_n: 1'h1,
      rx_cmd: 1'h0, overrun: 1'h0, rx: RX_IDLE, tx: TX_IDLE};

   hspcs_dv_st_t st_r;
   hspcs_dv_st_t st_nxt;
   logic [DIV_W-1:0] div;
   logic fifo_in_ready;
   logic [CNT_W-1:0] fifo_count;
   logic [FIFO_W-1:0] fifo_out;
   logic tx_fire;

   assign div = baud_div(st_r.rate, CLK_HZ_P);
   assign tx_ready = ce & ~st_r.tx.busy & (st_r.state == DV_RUN);
   assign tx_fire = tx_valid & tx_ready;

   // Receive path and transmit path run independently
   hspcs_fifo #(
      .W(FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .in_data({st_r.rx_cmd, st_r.rx.data}),
      .in_valid(st_r.rx.done),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .count(fifo_count)
   );

   always_comb begin
      st_nxt = st_r;
      st_nxt.restore = 1'h0;
      st_nxt.s_rxd1 = link.rxd;
      st_nxt.s_rxd2 = st_r.s_rxd1;
      st_nxt.s_cmd1 = link.cmd_n;
      st_nxt.s_cmd2 = st_r.s_cmd1;
      st_nxt.cmd_mode = ~st_r.s_cmd2;
      unique case (st_r.state)
         DV_BOOT: begin
            // Wait until the synchroniser holds the real pin level
            if (st_r.settle == 2'(SETTLE - 1)) begin
               st_nxt.state = st_r.s_cmd2 ? DV_RUN : DV_HOLD;
            end else begin
               st_nxt.settle = st_r.settle + 2'h1;
            end
         end
         DV_HOLD: begin
            // Defaults apply only once the host lets the line go high
            if (st_r.s_cmd2) begin
               st_nxt.state = DV_RUN;
               st_nxt.restore = 1'h1;
               st_nxt.rate = RATE_DEFAULT;
            end
         end
         DV_RUN: begin
            if (rate_wr) begin
               st_nxt.rate = rate_sel;
            end
         end
      endcase

      st_nxt.rx = rx_step(st_r.rx, st_r.s_rxd2, div);
      if (st_nxt.rx.done) begin
         // Tag each byte with the mode it arrived
         st_nxt.rx_cmd = ~st_r.s_cmd2;
      end
      st_nxt.overrun = st_r.rx.done & ~fifo_in_ready;

      if (tx_fire) begin
         st_nxt.tx = tx_load(tx_data, div);
      end else begin
         st_nxt.tx = tx_step(st_r.tx, div);
      end

      // Slack covers a byte already on the wire when the host sees high
      st_nxt.cts_n = (st_r.state != DV_RUN) | (fifo_count >= CTS_LIMIT);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_r <= ST_RST;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign link.txd = st_r.tx.line;
   assign link.cts_n = st_r.cts_n;
   assign rx_data = fifo_out[7:0];
   assign rx_cmd = fifo_out[8];
   assign rx_overrun = st_r.overrun;
   assign cmd_mode = st_r.cmd_mode;
   assign rate = st_r.rate;
   assign defaults_restored = st_r.restore;
endmodule : hspcs_device

// >>> hspcs_pkg.sv
// Shared constants, types and serial bit engines for the host serial port
package hspcs_pkg;

   // Clock and timing
   localparam int CLK_HZ = 200_000_000;
   localparam int CLK_NS = 5;
   localparam int T_RST_US = 20;
   localparam int RST_CYC = (T_RST_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int T_FACT_MS = 450;
   localparam longint FACT_CYC = (longint'(T_FACT_MS) * 1_000_000 + CLK_NS - 1) / CLK_NS;
   localparam int SETTLE = 3;

   // Character framing
   localparam int DIV_W = 20;
   localparam int DATA_W = 8;
   localparam int STOP_BIT = 9;

   // Receive buffer and flow control
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_W = 9;
   localparam int CTS_SLACK = 2;

   // Bit rates, selected by a 3-bit code
   localparam logic [2:0] RATE_DEFAULT = 3'h0;
   localparam int BPS_2400 = 2400;
   localparam int BPS_9600 = 9600;
   localparam int BPS_19200 = 19200;
   localparam int BPS_38400 = 38400;
   localparam int BPS_57600 = 57600;
   localparam int BPS_115200 = 115200;
   localparam int BPS_10400 = 10400;
   localparam int BPS_31250 = 31250;

   typedef enum logic [2:0] {
      DV_BOOT = 3'b001,
      DV_HOLD = 3'b010,
      DV_RUN = 3'b100
   } hspcs_dv_state_t;

   typedef enum logic [2:0] {
      HS_IDLE = 3'b001,
      HS_RST = 3'b010,
      HS_HOLD = 3'b100
   } hspcs_hs_state_t;

   typedef struct packed {
      logic busy;
      logic [DIV_W-1:0] cnt;
      logic [3:0] idx;
      logic [7:0] sh;
      logic [7:0] data;
      logic done;
   } hspcs_rx_t;

   typedef struct packed {
      logic busy;
      logic [DIV_W-1:0] cnt;
      logic [3:0] idx;
      logic [9:0] sh;
      logic line;
   } hspcs_tx_t;

   localparam hspcs_rx_t RX_IDLE = '{busy: 1'h0, cnt: 20'h0, idx: 4'h0, sh: 8'h00,
                                     data: 8'h00, done: 1'h0};
   localparam hspcs_tx_t TX_IDLE = '{busy: 1'h0, cnt: 20'h0, idx: 4'h0, sh: 10'h3FF,
                                     line: 1'h1};

   // Cycles per bit; floor division, error stays well under one percent at CLK_HZ
   function automatic logic [DIV_W-1:0] baud_div(input logic [2:0] sel, input int clk_hz);
      int bps;
      bps = BPS_2400;
      unique case (sel)
         3'h0: bps = BPS_2400;
         3'h1: bps = BPS_9600;
         3'h2: bps = BPS_19200;
         3'h3: bps = BPS_38400;
         3'h4: bps = BPS_57600;
         3'h5: bps = BPS_115200;
         3'h6: bps = BPS_10400;
         3'h7: bps = BPS_31250;
      endcase
      return DIV_W'(clk_hz / bps);
   endfunction : baud_div

   // Receiver: samples mid-bit, start, 8 data LSB first, stop
   function automatic hspcs_rx_t rx_step(input hspcs_rx_t s, input logic din,
                                         input logic [DIV_W-1:0] div);
      hspcs_rx_t r;
      r = s;
      r.done = 1'h0;
      if (!s.busy) begin
         if (!din) begin
            r.busy = 1'h1;
            r.cnt = div >> 1;
            r.idx = 4'h0;
         end
      end else if (s.cnt != 20'h0) begin
         r.cnt = s.cnt - 20'h1;
      end else begin
         r.cnt = div - 20'h1;
         if (s.idx == 4'h0) begin
            // A glitch that is high again at mid-start is not a character
            r.busy = ~din;
            r.idx = 4'h1;
         end else if (s.idx <= 4'(DATA_W)) begin
            r.sh = {din, s.sh[7:1]};
            r.idx = s.idx + 4'h1;
         end else begin
            r.busy = 1'h0;
            // A missing stop bit drops the character
            if (din) begin
               r.data = s.sh;
               r.done = 1'h1;
            end
         end
      end
      return r;
   endfunction : rx_step

   function automatic hspcs_tx_t tx_load(input logic [7:0] data, input logic [DIV_W-1:0] div);
      hspcs_tx_t r;
      r.busy = 1'h1;
      r.cnt = div - 20'h1;
      r.idx = 4'h0;
      r.sh = {1'h1, data, 1'h0};
      r.line = 1'h0;
      return r;
   endfunction : tx_load

   function automatic hspcs_tx_t tx_step(input hspcs_tx_t s, input logic [DIV_W-1:0] div);
      hspcs_tx_t r;
      r = s;
      if (s.busy) begin
         if (s.cnt != 20'h0) begin
            r.cnt = s.cnt - 20'h1;
         end else if (s.idx == 4'(STOP_BIT)) begin
            r.busy = 1'h0;
            r.line = 1'h1;
         end else begin
            r.sh = {1'h1, s.sh[9:1]};
            r.idx = s.idx + 4'h1;
            r.cnt = div - 20'h1;
            r.line = r.sh[0];
         end
      end
      return r;
   endfunction : tx_step

endpackage : hspcs_pkg

// >>> hspcs_link_if.sv
// Four host lines plus the host-driven module reset
`timescale 1ns/1ps
interface hspcs_link_if;
   logic rxd;
   logic txd;
   logic cts_n;
   logic cmd_n;
   logic dev_rst;

   // Exactly four lines between the two serial ends
   modport dev(input rxd, input cmd_n, output txd, output cts_n);
   modport host(output rxd, output cmd_n, output dev_rst, input txd, input cts_n);
endinterface : hspcs_link_if

// >>> hspcs_host.sv
// Host-side serial port: flow-controlled sender, receiver, command and reset control
`timescale 1ns/1ps

module hspcs_host
   import hspcs_pkg::*;
#(
   parameter int CLK_HZ_P = CLK_HZ,
   parameter int HOLD_CYC = int'(FACT_CYC)
) (
   // Clock, reset and enable
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   // Lines to the module
   hspcs_link_if.host link,
   // Bytes to send
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   // Bytes received
   output logic [7:0] rx_data,
   output logic rx_valid,
   // Mode, rate and factory restore
   input wire logic cmd_mode_req,
   input wire logic [2:0] rate_sel,
   input wire logic factory_req,
   output logic factory_busy
);
   typedef struct packed {
      hspcs_hs_state_t state;
      logic [31:0] cnt;
      logic s_txd1;
      logic s_txd2;
      logic s_cts1;
      logic s_cts2;
      logic cmd_n;
      logic dev_rst;
      hspcs_rx_t rx;
      hspcs_tx_t tx;
   } hspcs_hs_st_t;

   localparam hspcs_hs_st_t ST_RST = '{
      state: HS_IDLE, cnt: 32'h0, s_txd1: 1'h1, s_txd2: 1'h1, s_cts1: 1'h1, s_cts2: 1'h1,
      cmd_n: 1'h1, dev_rst: 1'h0, rx: RX_IDLE, tx: TX_IDLE};

   hspcs_hs_st_t st_r;
   hspcs_hs_st_t st_nxt;
   logic [DIV_W-1:0] div;
   logic tx_fire;

   assign div = baud_div(rate_sel, CLK_HZ_P);
   // A new byte starts only while the module shows clear-to-send low
   assign tx_ready = ce & ~st_r.tx.busy & ~st_r.s_cts2 & (st_r.state == HS_IDLE);
   assign tx_fire = tx_valid & tx_ready;

   always_comb begin
      st_nxt = st_r;
      st_nxt.s_txd1 = link.txd;
      st_nxt.s_txd2 = st_r.s_txd1;
      st_nxt.s_cts1 = link.cts_n;
      st_nxt.s_cts2 = st_r.s_cts1;
      unique case (st_r.state)
         HS_IDLE: begin
            st_nxt.cmd_n = ~cmd_mode_req;
            if (factory_req) begin
               st_nxt.state = HS_RST;
               st_nxt.cnt = 32'h0;
               st_nxt.cmd_n = 1'h0;
               st_nxt.dev_rst = 1'h1;
            end
         end
         HS_RST: begin
            if (st_r.cnt == 32'(RST_CYC - 1)) begin
               st_nxt.state = HS_HOLD;
               st_nxt.cnt = 32'h0;
               st_nxt.dev_rst = 1'h0;
            end else begin
               st_nxt.cnt = st_r.cnt + 32'h1;
            end
         end
         HS_HOLD: begin
            // Keep command low through the restore window after reset ends
            if (st_r.cnt == 32'(HOLD_CYC - 1)) begin
               st_nxt.state = HS_IDLE;
               st_nxt.cmd_n = 1'h1;
            end else begin
               st_nxt.cnt = st_r.cnt + 32'h1;
            end
         end
      endcase

      st_nxt.rx = rx_step(st_r.rx, st_r.s_txd2, div);
      if (tx_fire) begin
         st_nxt.tx = tx_load(tx_data, div);
      end else begin
         st_nxt.tx = tx_step(st_r.tx, div);
      end
   end

   // Reset value keeps command high so a power-up never wipes settings
   always_ff @(posedge clock) begin
      if (rst) begin
         st_r <= ST_RST;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign link.rxd = st_r.tx.line;
   assign link.cmd_n = st_r.cmd_n;
   assign link.dev_rst = st_r.dev_rst;
   assign rx_data = st_r.rx.data;
   assign rx_valid = st_r.rx.done;
   assign factory_busy = (st_r.state != HS_IDLE);
endmodule : hspcs_host

// >>> hspcs_chk.sv
// Link-level assertions for the host serial port, both ends joined
`timescale 1ns/1ps
module hspcs_chk #(
   parameter int DIV = 17
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Link lines
   input wire logic rxd,
   input wire logic txd,
   input wire logic cts_n,
   input wire logic cmd_n,
   input wire logic dev_rst
);
   localparam int MID = DIV / 2;
   localparam int STOP_AT = 9 * DIV + DIV / 2;
   typedef struct packed {
      logic txd_q;
      logic rxd_q;
      logic [9:0] tfc;
      logic [9:0] rfc;
   } hspcs_chk_st_t;
   hspcs_chk_st_t st_r, st_nxt;
   logic t_start, r_start;

   // A fall counts as a start only once the previous frame has run out
   always_comb begin
      t_start = st_r.txd_q && !txd && st_r.tfc == 10'h000;
      r_start = st_r.rxd_q && !rxd && st_r.rfc == 10'h000;
      st_nxt = st_r;
      st_nxt.txd_q = txd;
      st_nxt.rxd_q = rxd;
      if (t_start) begin
         st_nxt.tfc = 10'(10 * DIV - 1);
      end else if (st_r.tfc != 10'h000) begin
         st_nxt.tfc = st_r.tfc - 10'h001;
      end
      if (r_start) begin
         st_nxt.rfc = 10'(10 * DIV - 1);
      end else if (st_r.rfc != 10'h000) begin
         st_nxt.rfc = st_r.rfc - 10'h001;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_r <= {1'h1, 1'h1, 20'h00000};
      end else begin
         st_r <= st_nxt;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_idle_after_reset: assert property ($fell(rst) |->
      txd && rxd && cts_n && cmd_n && !dev_rst)
      else $error("link not idle after reset");
   a_cts_boot: assert property ($fell(rst) |-> cts_n [*3])
      else $error("clear-to-send low too soon after reset");
   a_cts_in_reset: assert property (dev_rst |=> cts_n)
      else $error("clear-to-send low while module reset");
   a_host_waits_cts: assert property (r_start |-> !$past(cts_n, 3) || !$past(cts_n, 4))
      else $error("host started a character while held off");
   a_tx_start_mid: assert property (t_start |-> ##MID !txd)
      else $error("module start bit too short");
   a_tx_stop_bit: assert property (t_start |-> ##STOP_AT txd)
      else $error("module stop bit missing");
   a_rx_start_mid: assert property (r_start |-> ##MID !rxd)
      else $error("host start bit too short");
   a_rx_stop_bit: assert property (r_start |-> ##STOP_AT rxd)
      else $error("host stop bit missing");
   a_restore_cmd_low: assert property ($rose(dev_rst) |-> !cmd_n)
      else $error("restore reset without command low");
   a_restore_hold: assert property ($fell(dev_rst) |-> !cmd_n [*8])
      else $error("command released too soon after reset");

   c_tx_frame: cover property (t_start);
   c_rx_frame: cover property (r_start);
   c_cts_stop: cover property ($rose(cts_n));
   c_restore: cover property ($fell(dev_rst));
endmodule : hspcs_chk

// >>> host_serial_port_command_select_test.sv
// Self-checking bench: host end and module end joined over the serial link
`timescale 1ns/1ps
module host_serial_port_command_select_test;
   import hspcs_pkg::*;
   // Slow clock figure keeps a bit at 17 cycles, same on both ends
   localparam int CLK_P = 2_000_000;
   localparam int SPAN = 60000;
   logic clock = 1'h0;
   logic rst = 1'h1;
   logic d_rst;
   logic [7:0] d_rx_data, d_tx_data, h_tx_data, h_rx_data;
   logic d_rx_cmd, d_rx_valid, d_rx_ready, d_rx_overrun, d_tx_valid, d_tx_ready, d_cmd_mode;
   logic [2:0] d_rate_sel, d_rate;
   logic d_rate_wr, d_restored, h_tx_valid, h_tx_ready, h_rx_valid, h_cmd_req, h_fact_req;
   logic hold, cmd_exp;
   logic h_fact_busy;
   logic [15:0] seed = 16'h0010;
   logic [8:0] d_q[$];
   logic [7:0] h_q[$];
   int failures = 0;
   int total_checks = 0;
   int restores = 0;

   always #2.5 clock = ~clock;

   hspcs_link_if link();
   assign d_rst = rst | link.dev_rst;

   hspcs_device #(.CLK_HZ_P(CLK_P)) u_hspcs_device (.clock(clock), .rst(d_rst), .ce(1'h1),
      .link(link), .rx_data(d_rx_data), .rx_cmd(d_rx_cmd), .rx_valid(d_rx_valid),
      .rx_ready(d_rx_ready), .rx_overrun(d_rx_overrun), .tx_data(d_tx_data),
      .tx_valid(d_tx_valid), .tx_ready(d_tx_ready), .cmd_mode(d_cmd_mode),
      .rate_sel(d_rate_sel), .rate_wr(d_rate_wr), .rate(d_rate), .defaults_restored(d_restored));
   hspcs_host #(.CLK_HZ_P(CLK_P), .HOLD_CYC(200)) u_hspcs_host (.clock(clock), .rst(rst),
      .ce(1'h1), .link(link), .tx_data(h_tx_data), .tx_valid(h_tx_valid), .tx_ready(h_tx_ready),
      .rx_data(h_rx_data), .rx_valid(h_rx_valid), .cmd_mode_req(h_cmd_req), .rate_sel(3'h5),
      .factory_req(h_fact_req), .factory_busy(h_fact_busy));
   hspcs_chk #(.DIV(CLK_P / 115200)) u_hspcs_chk (.clock(clock), .rst(rst), .rxd(link.rxd),
      .txd(link.txd), .cts_n(link.cts_n), .cmd_n(link.cmd_n), .dev_rst(link.dev_rst));

   function automatic logic [15:0] xs(input logic [15:0] v);
      logic [15:0] r;
      r = v ^ (v << 7);
      r = r ^ (r >> 9);
      r = r ^ (r << 8);
      return r;
   endfunction : xs

   // Random back-pressure on the receive side unless a scenario holds it
   always @(posedge clock) begin
      seed <= xs(seed);
      d_rx_ready <= !hold && seed[3];
   end

   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   task automatic stop_test();
      $display("checks %0d, failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test

   always @(negedge clock) begin
      if (d_rx_valid === 1'h1 && d_rx_ready === 1'h1) begin
         check("module rx byte", {d_rx_cmd, d_rx_data}, d_q.pop_front());
      end
      if (h_rx_valid === 1'h1) begin
         check("host rx byte", {1'h0, h_rx_data}, {1'h0, h_q.pop_front()});
      end
      if (d_rx_overrun === 1'h1) begin
         check("overrun", 9'h001, 9'h000);
      end
      if (d_restored === 1'h1) begin
         restores++;
      end
   end

   task automatic h_send();
      int n;
      @(posedge clock);
      h_tx_data <= seed[15:8];
      h_tx_valid <= 1'h1;
      n = 0;
      do begin @(negedge clock); n++; end while (h_tx_ready !== 1'h1 && n < 4000);
      // A host that never gets clear-to-send counts as a mismatch
      check("host tx ready", {8'h00, h_tx_ready}, 9'h001);
      @(posedge clock);
      d_q.push_back({cmd_exp, h_tx_data});
      h_tx_valid <= 1'h0;
   endtask : h_send

   task automatic d_send();
      int n;
      @(posedge clock);
      d_tx_data <= seed[11:4];
      d_tx_valid <= 1'h1;
      n = 0;
      do begin @(negedge clock); n++; end while (d_tx_ready !== 1'h1 && n < 4000);
      check("module tx ready", {8'h00, d_tx_ready}, 9'h001);
      @(posedge clock);
      h_q.push_back(d_tx_data);
      d_tx_valid <= 1'h0;
   endtask : d_send

   task automatic set_rate(input logic [2:0] k);
      int n;
      n = 0;
      do begin @(negedge clock); n++; end while (d_tx_ready !== 1'h1 && n < 20000);
      check("module running", {8'h00, d_tx_ready}, 9'h001);
      @(posedge clock);
      d_rate_sel <= k;
      d_rate_wr <= 1'h1;
      @(posedge clock);
      d_rate_wr <= 1'h0;
      @(negedge clock);
      check("rate code", {6'h00, d_rate}, {6'h00, k});
   endtask : set_rate

   // Both directions at once, then wait until every byte has arrived
   task automatic duplex(input int cnt);
      int n;
      fork
         repeat (cnt) h_send();
         repeat (cnt) d_send();
      join
      for (n = 0; n < 20000 && d_q.size() + h_q.size() > 0; n++) @(negedge clock);
      // Bytes still owed after the wait mean a lost character
      check("bytes outstanding", 9'(d_q.size() + h_q.size()), 9'h000);
   endtask : duplex

   initial begin
      repeat (SPAN) @(posedge clock);
      failures++;
      stop_test();
   end

   initial begin
      int n;
      {d_tx_data, d_tx_valid, d_rate_sel, d_rate_wr} = 13'h0000;
      {h_tx_data, h_tx_valid, h_cmd_req, h_fact_req, hold, cmd_exp} = 13'h0000;
      repeat (20) @(posedge clock);
      rst <= 1'h0;
      for (int k = 0; k < 8; k++) set_rate(3'(k));
      set_rate(3'h5);
      check("command mode", {8'h00, d_cmd_mode}, 9'h000);
      duplex(6);
      @(posedge clock);
      h_cmd_req <= 1'h1;
      cmd_exp = 1'h1;
      repeat (10) @(negedge clock);
      check("command mode", {8'h00, d_cmd_mode}, 9'h001);
      duplex(3);
      @(posedge clock);
      h_cmd_req <= 1'h0;
      cmd_exp = 1'h0;
      repeat (10) @(negedge clock);
      // Stall the module until clear-to-send goes high, then drain it
      hold = 1'h1;
      fork
         repeat (8) h_send();
         begin
            for (n = 0; n < 4000 && link.cts_n !== 1'h1; n++) @(negedge clock);
            repeat (400) @(negedge clock);
            check("clear to send", {8'h00, link.cts_n}, 9'h001);
            check("host held off", {8'h00, h_tx_ready}, 9'h000);
            hold = 1'h0;
         end
      join
      duplex(0);
      @(posedge clock);
      h_fact_req <= 1'h1;
      @(posedge clock);
      h_fact_req <= 1'h0;
      @(negedge clock);
      check("factory busy", {8'h00, h_fact_busy}, 9'h001);
      for (n = 0; n < 20000 && restores == 0; n++) @(negedge clock);
      check("restores", 9'(restores), 9'h001);
      check("factory busy", {8'h00, h_fact_busy}, 9'h000);
      check("default rate", {6'h00, d_rate}, 9'h000);
      set_rate(3'h5);
      duplex(2);
      stop_test();
   end
endmodule : host_serial_port_command_select_test
